// *** design/sfp_top.sv ***
/*
 Pin front end of a small serial flash: oversamples the serial pins,
 shifts bytes in and out, tracks selection, pause and write protection.
 Assumes the system clock is well above the serial clock rate and that
 the flash core supplies the busy level, region hit and outgoing bytes.
*/
`timescale 1ns/1ps
module sfp_top
   import sfp_pkg::*;
(
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RESETN,
   // Serial pins
   input  wire logic              SCK,
   input  wire logic              CS_N,
   input  wire logic              SI,
   input  wire logic              PAUSE_N,
   input  wire logic              WP_N,
   output logic                   SO_OUT,
   output logic                   SO_OE_N,
   // Received bytes
   output logic [BYTE_W-1:0]      RX_DATA,
   output logic                   RX_VALID,
   input  wire logic              RX_READY,
   output logic                   RX_OVERRUN,
   // Bytes to send
   input  wire logic [BYTE_W-1:0] TX_DATA,
   input  wire logic              TX_VALID,
   output logic                   TX_READY,
   // Core status and protection
   input  wire logic              BUSY,
   input  wire logic              REGION_HIT,
   input  wire logic [LVL_W-1:0]  PROTECT_LEVEL,
   output logic                   SELECTED,
   output logic                   STANDBY,
   output logic                   WR_COMMIT,
   output logic                   WR_DISCARD,
   output logic                   WR_BLOCKED
);
   // Pin synchronisers: stage 1 feeds stage 2 only
   logic [4:0] s1_reg;
   logic [4:0] s2_reg;
   logic [4:0] s3_reg;
   // Chip select resets low: a pin held low gives no false fall
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s1_reg <= SYNC_RST;
         s2_reg <= SYNC_RST;
         s3_reg <= SYNC_RST;
      end else begin
         s1_reg <= {SCK, CS_N, SI, PAUSE_N, WP_N};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   wire sck_s   = s2_reg[4];
   wire cs_n_s  = s2_reg[3];
   wire si_s    = s2_reg[2];
   wire pause_s = s2_reg[1];
   wire wp_n_s  = s2_reg[0];
   wire sck_rise = sck_s && !s3_reg[4];
   wire sck_fall = !sck_s && s3_reg[4];
   wire cs_fall  = !cs_n_s && s3_reg[3];
   wire cs_rise  = cs_n_s && !s3_reg[3];

   logic              armed_reg;
   logic [CNT_W-1:0]  bit_cnt_reg;
   logic              any_bits_reg;
   logic [BYTE_W-1:0] rx_sh_reg;
   logic [BYTE_W-1:0] tx_sh_reg;
   logic              loaded_reg;
   logic              buf_ready;

   // Selected once armed by a chip select fall, chip select low
   wire selected  = armed_reg && !cs_n_s;
   // Pause only counts while selected
   wire active    = selected && pause_s;
   wire take_bit  = active && sck_rise;
   wire byte_done = take_bit && (bit_cnt_reg == CNT_LAST);
   wire [BYTE_W-1:0] rx_next = {rx_sh_reg[BYTE_W-2:0], si_s};
   wire push      = byte_done && buf_ready;
   wire load_cs   = cs_fall;
   wire load_fall = active && sck_fall && bit_cnt_reg == CNT_ZERO &&
                    !loaded_reg;
   wire shift_out = active && sck_fall && bit_cnt_reg != CNT_ZERO;
   wire load_tx   = load_cs || load_fall;
   wire [BYTE_W-1:0] tx_byte = TX_VALID ? TX_DATA : TX_IDLE;
   wire aligned   = any_bits_reg && bit_cnt_reg == CNT_ZERO;
   wire protect   = !wp_n_s && REGION_HIT &&
                    PROTECT_LEVEL != LVL_NONE;
   wire end_frame = armed_reg && cs_rise;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         armed_reg <= 1'b0;
      end else if (cs_fall) begin
         armed_reg <= 1'b1;
      end
   end

   // Transfer state survives a pause untouched
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         bit_cnt_reg  <= CNT_ZERO;
         any_bits_reg <= 1'b0;
         rx_sh_reg    <= '0;
      end else if (cs_fall) begin
         bit_cnt_reg  <= CNT_ZERO;
         any_bits_reg <= 1'b0;
      end else if (take_bit) begin
         bit_cnt_reg  <= bit_cnt_reg + CNT_ONE;
         any_bits_reg <= 1'b1;
         rx_sh_reg    <= rx_next;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_sh_reg  <= TX_IDLE;
         loaded_reg <= 1'b0;
         SO_OUT     <= 1'b1;
      end else if (load_tx) begin
         SO_OUT     <= tx_byte[BYTE_W-1];
         tx_sh_reg  <= {tx_byte[BYTE_W-2:0], 1'b1};
         loaded_reg <= 1'b1;
      end else if (shift_out) begin
         SO_OUT     <= tx_sh_reg[BYTE_W-1];
         tx_sh_reg  <= {tx_sh_reg[BYTE_W-2:0], 1'b1};
      end else if (byte_done) begin
         loaded_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SO_OE_N    <= 1'b1;
         SELECTED   <= 1'b0;
         STANDBY    <= 1'b0;
         TX_READY   <= 1'b0;
         RX_OVERRUN <= 1'b0;
         WR_COMMIT  <= 1'b0;
         WR_DISCARD <= 1'b0;
         WR_BLOCKED <= 1'b0;
      end else begin
         SO_OE_N    <= !active;
         SELECTED   <= selected;
         STANDBY    <= cs_n_s && !BUSY;
         TX_READY   <= load_tx && TX_VALID;
         RX_OVERRUN <= RX_OVERRUN || (byte_done && !buf_ready);
         WR_COMMIT  <= end_frame && aligned && !protect;
         WR_DISCARD <= end_frame && !aligned;
         WR_BLOCKED <= end_frame && aligned && protect;
      end
   end

   sfp_buf2 #(
      .W (BYTE_W)
   ) u_rx_buf (
      .clk       (CLK),
      .resetn    (RESETN),
      .in_data   (rx_next),
      .in_valid  (byte_done),
      .in_ready  (buf_ready),
      .out_data  (RX_DATA),
      .out_valid (RX_VALID),
      .out_ready (RX_READY)
   );

   a_no_arm_take: assert property (@(posedge CLK) disable iff (!RESETN)
      !armed_reg |-> !take_bit && SO_OE_N)
      else $error("bit taken before first select");
   a_desel_float: assert property (@(posedge CLK) disable iff (!RESETN)
      cs_n_s |=> SO_OE_N)
      else $error("output driven while deselected");
   a_pause_float: assert property (@(posedge CLK) disable iff (!RESETN)
      !pause_s |=> SO_OE_N)
      else $error("output driven during pause");
   a_pause_hold: assert property (@(posedge CLK) disable iff (!RESETN)
      (!pause_s && !cs_n_s && !cs_fall) |=> $stable(bit_cnt_reg))
      else $error("transfer state moved during pause");
   a_select_drive: assert property (@(posedge CLK) disable iff (!RESETN)
      (selected && pause_s) |=> !SO_OE_N && SELECTED)
      else $error("selected device not driving");
   a_rise_capture: assert property (@(posedge CLK) disable iff (!RESETN)
      take_bit |=> rx_sh_reg[0] == $past(si_s))
      else $error("input bit not captured on rise");
   a_fall_only: assert property (@(posedge CLK) disable iff (!RESETN)
      $changed(SO_OUT) |-> $past(sck_fall) || $past(cs_fall))
      else $error("output changed off a falling edge");
   a_byte_push: assert property (@(posedge CLK) disable iff (!RESETN)
      push |=> RX_VALID)
      else $error("completed byte not buffered");
   a_standby: assert property (@(posedge CLK) disable iff (!RESETN)
      BUSY |=> !STANDBY)
      else $error("standby while busy");
   a_commit_align: assert property (@(posedge CLK) disable iff (!RESETN)
      WR_COMMIT |-> $past(bit_cnt_reg) == CNT_ZERO && !WR_DISCARD)
      else $error("commit on partial byte");
   a_protect_blk: assert property (@(posedge CLK) disable iff (!RESETN)
      (end_frame && protect) |=> !WR_COMMIT)
      else $error("write committed into protected region");
   a_msb_first: assert property (@(posedge CLK) disable iff (!RESETN)
      (load_tx && TX_VALID) |=> SO_OUT == $past(TX_DATA[BYTE_W-1]))
      else $error("first bit sent is not the top bit");
   a_overrun_set: assert property (@(posedge CLK) disable iff (!RESETN)
      (byte_done && !buf_ready) |=> RX_OVERRUN)
      else $error("lost byte not flagged");
endmodule

// *** design/sfp_pkg.sv ***
/*
 Constants shared by the serial flash pin front end and its byte buffer.
 Assumes a single system clock domain that oversamples the serial pins.
*/
package sfp_pkg;
   localparam int          BYTE_W    = 8;
   localparam int          CNT_W     = 3;
   localparam int          LVL_W     = 3;
   localparam logic [2:0]  CNT_ZERO  = 3'h0;
   localparam logic [2:0]  CNT_ONE   = 3'h1;
   localparam logic [2:0]  CNT_LAST  = 3'h7;
   localparam logic [2:0]  LVL_NONE  = 3'h0;
   localparam logic [7:0]  TX_IDLE   = 8'hFF;
   localparam logic [1:0]  FILL_ZERO = 2'h0;
   localparam logic [1:0]  FILL_ONE  = 2'h1;
   localparam logic [1:0]  FILL_FULL = 2'h2;
   // Pin sync reset: {SCK, CS_N, SI, PAUSE_N, WP_N}, chip select low
   localparam logic [4:0]  SYNC_RST  = 5'h17;
endpackage

// *** design/sfp_buf2.sv ***
/*
 Two-entry valid/ready buffer for received bytes.
 Assumes both sides run on the same clock; read data come from a register.
*/
`timescale 1ns/1ps
module sfp_buf2
   import sfp_pkg::*;
#(
   parameter int W = BYTE_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Fill side
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   // Drain side
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   logic [W-1:0] head_reg;
   logic [W-1:0] tail_reg;
   logic [1:0]   fill_reg;
   wire          push = in_valid && in_ready;
   wire          pop  = out_valid && out_ready;

   assign in_ready  = (fill_reg != FILL_FULL);
   assign out_data  = head_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fill_reg  <= FILL_ZERO;
         out_valid <= 1'b0;
         head_reg <= '0;
         tail_reg <= '0;
      end else begin
         // Head holds oldest word, tail the second
         if (pop) begin
            head_reg <= (fill_reg == FILL_FULL) ? tail_reg : in_data;
         end else if (push && fill_reg == FILL_ZERO) begin
            head_reg <= in_data;
         end
         if (push && (fill_reg == FILL_FULL ||
                      (fill_reg == FILL_ONE && !pop))) begin
            tail_reg <= in_data;
         end
         // Valid kept as its own flop, equal to a non-zero fill
         if (push && !pop) begin
            fill_reg  <= fill_reg + FILL_ONE;
            out_valid <= 1'b1;
         end else if (pop && !push) begin
            fill_reg  <= fill_reg - FILL_ONE;
            out_valid <= (fill_reg != FILL_ONE);
         end
      end
   end
endmodule

// *** verif/sfp_master.sv ***
/*
 Serial bus master model driving the flash front end pins.
 Assumes the bench calls its tasks one at a time; SCK period 125 ns.
*/
`timescale 1ns/1ps
module sfp_master (
   // Serial pins
   input  wire logic so,
   output logic      sck,
   output logic      cs_n,
   output logic      si
);
   logic mode3;
   initial begin
      sck   = 1'b0;
      cs_n  = 1'b1;
      si    = 1'b0;
      mode3 = 1'b0;
   end
   // Clock idles at the mode's level before select falls
   task start(input logic m3);
      mode3 = m3;
      sck   = m3;
      #200;
      cs_n  = 1'b0;
      #125;
   endtask
   // Bit set after the fall, held across the rise; SO taken at rise
   task shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         sck = 1'b0;
         si  = tx[7-i];
         #62.5;
         sck = 1'b1;
         rx  = {rx[6:0], so};
         #62.5;
      end
   endtask
   // Released data line shows the inverse of its last value
   task stop();
      if (!mode3) sck = 1'b0;
      #125;
      cs_n = 1'b1;
      si   = ~si;
      #250;
   endtask
endmodule

// *** verif/tb.sv ***
/*
 Self-checking bench for the serial flash pin front end.
 Assumes the master model in sfp_master and a 100 MHz system clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
num_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
   import sfp_pkg::*;
   typedef struct {logic m3; logic [7:0] tx; logic [7:0] si; int n;
      logic wp; logic hit; logic [2:0] lvl; logic [2:0] wr;} sfp_row_t;
   logic              CLK, RESETN, SCK, CS_N, SI, PAUSE_N, WP_N;
   logic              SO_OUT, SO_OE_N, RX_VALID, RX_READY, RX_OVERRUN;
   logic              TX_VALID, TX_READY, BUSY, REGION_HIT, SELECTED;
   logic              STANDBY, WR_COMMIT, WR_DISCARD, WR_BLOCKED;
   logic [7:0]        RX_DATA, TX_DATA, b1, b2;
   logic [2:0]        PROTECT_LEVEL, wr_seen;
   int                num_errors, total_checks, n_wr, n_tx;
   // Write kind as {commit, blocked, discard}
   sfp_row_t rows[6] = '{'{0, 8'hA5, 8'h3C, 8, 1, 1, 3'h3, 3'h4},
      '{1, 8'h5A, 8'hC3, 8, 0, 1, 3'h2, 3'h2},
      '{0, 8'h81, 8'h7E, 8, 0, 0, 3'h2, 3'h4},
      '{1, 8'hF0, 8'h0F, 5, 1, 0, 3'h0, 3'h1},
      '{0, 8'h69, 8'h96, 8, 0, 1, 3'h0, 3'h4},
      '{1, 8'h12, 8'h34, 0, 0, 1, 3'h7, 3'h1}};
   sfp_master m (.so(SO_OE_N ? ~SO_OUT : SO_OUT), .sck(SCK), .cs_n(CS_N),
      .si(SI));
   sfp_top dut (.CLK(CLK), .RESETN(RESETN), .SCK(SCK), .CS_N(CS_N),
      .SI(SI), .PAUSE_N(PAUSE_N), .WP_N(WP_N), .SO_OUT(SO_OUT),
      .SO_OE_N(SO_OE_N), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
      .RX_READY(RX_READY), .RX_OVERRUN(RX_OVERRUN), .TX_DATA(TX_DATA),
      .TX_VALID(TX_VALID), .TX_READY(TX_READY), .BUSY(BUSY),
      .REGION_HIT(REGION_HIT), .PROTECT_LEVEL(PROTECT_LEVEL),
      .SELECTED(SELECTED), .STANDBY(STANDBY), .WR_COMMIT(WR_COMMIT),
      .WR_DISCARD(WR_DISCARD), .WR_BLOCKED(WR_BLOCKED));
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // Frame end pulses and transmit takes
   always @(posedge CLK) begin
      n_wr += (WR_COMMIT === 1'b1) + (WR_BLOCKED === 1'b1);
      n_wr += (WR_DISCARD === 1'b1);
      wr_seen = wr_seen | {WR_COMMIT, WR_BLOCKED, WR_DISCARD};
      if (TX_READY === 1'b1) begin
         n_tx++;
         TX_VALID <= 1'b0;
      end
   end
   task tally_and_finish();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task frame_start(input logic m3, input logic [7:0] txb);
      @(posedge CLK) begin TX_DATA <= txb; TX_VALID <= 1'b1; end
      #1;
      wr_seen = 3'h0;
      n_wr    = 0;
      n_tx    = 0;
      m.start(m3);
      `CHK("selected", 1'b1, SELECTED)
      `CHK("standby", 1'b0, STANDBY)
      `CHK("so_oe_n", 1'b0, SO_OE_N)
   endtask
   task pop();
      @(posedge CLK) RX_READY <= 1'b1;
      @(posedge CLK) RX_READY <= 1'b0;
      @(posedge CLK);
   endtask
   initial begin
      {RESETN, RX_READY, TX_VALID, BUSY, REGION_HIT} = 5'h00;
      {PAUSE_N, WP_N, TX_DATA, PROTECT_LEVEL} = 13'h1800;
      {num_errors, total_checks, n_wr, n_tx, wr_seen} = '0;
      repeat (6) @(posedge CLK);
      RESETN <= 1'b1;
      foreach (rows[k]) begin
         @(posedge CLK) begin
            WP_N          <= rows[k].wp;
            REGION_HIT    <= rows[k].hit;
            PROTECT_LEVEL <= rows[k].lvl;
         end
         frame_start(rows[k].m3, rows[k].tx);
         m.shift(rows[k].si, rows[k].n, b1);
         m.stop();
         `CHK("so_byte", rows[k].tx >> (8 - rows[k].n), b1)
         `CHK("wr_kind", rows[k].wr, wr_seen)
         `CHK("wr_count", 1, n_wr)
         `CHK("tx_taken", 1, n_tx)
         `CHK("so_float", 1'b1, SO_OE_N)
         `CHK("rx_valid", rows[k].n == 8, RX_VALID)
         if (rows[k].n == 8) begin
            `CHK("rx_data", rows[k].si, RX_DATA)
            pop();
         end
      end
      // Pause in mid-byte keeps the transfer state
      frame_start(1'b0, 8'hA5);
      m.shift(8'h96, 4, b1);
      @(posedge CLK) PAUSE_N <= 1'b0;
      #101;
      m.shift(8'hFF, 2, b2);
      `CHK("pause_oe", 1'b1, SO_OE_N)
      @(posedge CLK) PAUSE_N <= 1'b1;
      #101;
      `CHK("resume_oe", 1'b0, SO_OE_N)
      m.shift(8'h60, 4, b2);
      m.stop();
      `CHK("pause_so", 8'hA5, {b1[3:0], b2[3:0]})
      `CHK("pause_rx", 8'h96, RX_DATA)
      `CHK("pause_wr", 3'h2, wr_seen)
      pop();
      // Standby waits for the core to finish
      @(posedge CLK) BUSY <= 1'b1;
      repeat (6) @(posedge CLK);
      `CHK("standby_busy", 1'b0, STANDBY)
      BUSY <= 1'b0;
      repeat (6) @(posedge CLK);
      `CHK("standby_idle", 1'b1, STANDBY)
      // Third byte with two held overruns; order kept
      frame_start(1'b1, 8'h00);
      for (int i = 1; i < 4; i++) m.shift(8'(8'hC0 + i), 8, b1);
      m.stop();
      `CHK("overrun", 1'b1, RX_OVERRUN)
      `CHK("fifo_head", 8'hC1, RX_DATA)
      pop();
      `CHK("fifo_next", 8'hC2, RX_DATA)
      pop();
      `CHK("fifo_empty", 1'b0, RX_VALID)
      // Reset with select already low: not armed until it falls
      m.start(1'b0);
      @(posedge CLK) RESETN <= 1'b0;
      repeat (6) @(posedge CLK);
      `CHK("rst_oe", 1'b1, SO_OE_N)
      `CHK("rst_ovr", 1'b0, RX_OVERRUN)
      RESETN <= 1'b1;
      #1;
      n_wr = 0;
      m.shift(8'h3C, 8, b1);
      `CHK("unarmed_sel", 1'b0, SELECTED)
      m.stop();
      `CHK("unarmed_rx", 1'b0, RX_VALID)
      `CHK("unarmed_wr", 0, n_wr)
      tally_and_finish();
   end
   initial begin
      #300000;
      num_errors++;
      tally_and_finish();
   end
endmodule
